/* hw/ccs_top.sv */
// Purpose: Compressor staging controller for a chiller or heat pump, APB slave.
// Assumes: One 25 MHz clock, synchronous reset, pins synchronised here.
// Notes:   Register writes land at the APB access edge; reads are staged one cycle.
// What this block does
// - Control type 0 selects side band, 1 selects dead band control.
// - Summer side band adds steps as inlet rises across proportional band.
// - Winter side band sits below setpoint, adds steps as inlet falls.
// - Inside the dead band no switch-on or switch-off is requested.
// - Summer dead band: above band switch on, below band switch off.
// - Winter dead band: below band switch on, above band switch off.
// - Setpoints are clamped to their chiller or heat pump limits.
// - Still outside after extra or release time, one more step is requested.
// - Self adapt uses configured band at start, then tunes it from starts.
// - Two circuits regulate on the outlet average, or the working probe.
// - Both outlet probes failed means no regulation and no requests.
// - Up to three equal compressors per circuit, six in total.
// - Each compressor is in one of seven states.
// - Running hours per compressor are readable; writing zero clears them.
// - Alarm and manual units leave rotation; others replace them.
// - FIFO switches off the earliest started running compressor.
// - FIFO starts the unit after the last one switched off.
// - LIFO switches off the most recently started compressor.
// - Hour modes start fewest hours, stop most hours, ties by order.
// - Share 0 alternates steps between circuits.
// - Share 1 fills the first circuit before the second.
// - A started compressor stays on for at least the minimum on time, unless it trips, goes to manual or is deconfigured.
// - At the hourly start limit further starts wait.
`default_nettype none
`include "ccs_map.svh"

module ccs_top import ccs_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `CCS_CLK_HZ * `CCS_TICK_S
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic [15:0] i_inlet_temp,
  input  wire logic [15:0] i_outlet_temp_a,
  input  wire logic [15:0] i_outlet_temp_b,
  input  wire logic [1:0]  i_probe_fail,
  input  wire logic [5:0]  i_prot_trip,
  input  wire logic [5:0]  i_manual_mode,
  output logic [5:0]       o_comp_on
);

  ccs_pins_t pin_in, s1_q, s2_q;
  assign pin_in = '{inlet: i_inlet_temp, out_a: i_outlet_temp_a, out_b: i_outlet_temp_b,
                    fail: i_probe_fail, prot: i_prot_trip, man: i_manual_mode};

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (i_ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end

  localparam logic [15:0] CFG_RST [`CCS_NCFG] = `CCS_RST_CFG;
  logic [15:0] ctrl_q;
  logic [15:0] cfg_q [`CCS_NCFG];
  logic        wr_en;
  logic        cfg_hit;
  logic        hrs_hit;
  logic [3:0]  cfg_ix;
  logic [2:0]  hrs_ix;

  assign o_pready = i_ce;
  assign wr_en    = i_psel & i_penable & i_pwrite & i_ce;
  assign cfg_ix   = 4'((i_paddr - `CCS_A_CFG_LO) >> 2);
  assign hrs_ix   = 3'((i_paddr - `CCS_A_HRS_LO) >> 2);
  assign cfg_hit  = i_paddr >= `CCS_A_CFG_LO && i_paddr <= `CCS_A_CFG_HI && i_paddr[1:0] == 2'h0;
  assign hrs_hit  = i_paddr >= `CCS_A_HRS_LO && i_paddr <= `CCS_A_HRS_HI && i_paddr[1:0] == 2'h0;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_q <= `CCS_CTRL_RST;
      for (int k = 0; k < `CCS_NCFG; k++) cfg_q[k] <= CFG_RST[k];
    end else if (wr_en) begin
      if (i_paddr == `CCS_A_CTRL) ctrl_q <= i_pwdata[15:0];
      if (cfg_hit) cfg_q[cfg_ix] <= i_pwdata[15:0];
    end
  end

  logic       winter, adapt, share, twin, run_en, hmode, fifo;
  logic [1:0] cpc;
  logic [2:0] n_steps;
  logic [7:0] max_st;
  assign winter  = ctrl_q[`CCS_F_WINTER];
  assign adapt   = ctrl_q[`CCS_F_ADAPT];
  assign share   = ctrl_q[`CCS_F_SHARE];
  assign twin    = ctrl_q[`CCS_F_NCIRC] == `CCS_TWIN;
  assign cpc     = ctrl_q[`CCS_F_CPC];
  assign run_en  = ctrl_q[`CCS_F_RUN];
  assign hmode   = ctrl_q[`CCS_F_HOURS];
  assign fifo    = !ctrl_q[`CCS_F_LIFO];
  assign n_steps = twin ? {cpc, 1'b0} : {1'b0, cpc};
  assign max_st  = cfg_q[`CCS_IX_MAXST][7:0];

  logic [24:0] sec_cnt_q;
  logic [11:0] hr_cnt_q;
  logic        tick, hour_tick;
  assign tick      = i_ce && sec_cnt_q == 25'(SEC_CYCLES - 1);
  assign hour_tick = tick && hr_cnt_q == 12'(`CCS_HOUR_S - 1);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sec_cnt_q <= '0;
      hr_cnt_q  <= '0;
    end else if (i_ce) begin
      sec_cnt_q <= tick ? 25'h0 : sec_cnt_q + 25'h1;
      if (hour_tick) hr_cnt_q <= 12'h0;
      else if (tick) hr_cnt_q <= hr_cnt_q + 12'h1;
    end
  end

  // Probe selection.
  logic signed [16:0] t_sum;
  logic signed [15:0] t_out, t_in, sp, half;
  logic               reg_ok;
  assign t_sum = $signed({s2_q.out_a[15], s2_q.out_a}) + $signed({s2_q.out_b[15], s2_q.out_b});
  assign t_in  = $signed(s2_q.inlet);

  always_comb begin
    reg_ok = 1'b1;
    t_out  = $signed(s2_q.out_a);
    if (twin && s2_q.fail == 2'h0) begin
      t_out = t_sum[16:1];
    end else if (twin && !s2_q.fail[1]) begin
      t_out = $signed(s2_q.out_b);
    end else if (s2_q.fail[0]) begin
      reg_ok = 1'b0;
    end
  end

  function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign sp = winter ?
    clamp16(cfg_q[`CCS_IX_SP_WIN], cfg_q[`CCS_IX_HT_LO], cfg_q[`CCS_IX_HT_HI]) :
    clamp16(cfg_q[`CCS_IX_SP_SUM], cfg_q[`CCS_IX_CH_LO], cfg_q[`CCS_IX_CH_HI]);

  // Compressor bookkeeping arrays.
  ccs_cmp_state_t st_q [`CCS_NCOMP];
  ccs_cmp_state_t st_d [`CCS_NCOMP];
  logic [15:0]    hrs_q [`CCS_NCOMP];
  logic [7:0]     age [`CCS_NCOMP];
  logic [5:0]     cfgd, on_m, off_m;
  logic [7:0]     seq_q, hr_starts_q;
  logic [2:0]     last_off_q, running, pick_on, pick_off;
  logic           last_circ_q, found_on, found_off;

  logic [15:0] band_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      band_q <= `CCS_RST_DBAND;
    end else if (i_ce) begin
      if (!run_en || !adapt) begin
        band_q <= cfg_q[`CCS_IX_DBAND];
      end else if (hour_tick && hr_starts_q > max_st && band_q < cfg_q[`CCS_IX_BMAX]) begin
        band_q <= band_q + 16'h1;
      end else if (hour_tick && hr_starts_q < max_st && band_q > cfg_q[`CCS_IX_BMIN]) begin
        band_q <= band_q - 16'h1;
      end
    end
  end
  assign half = $signed({1'b0, band_q[15:1]});

  logic signed [23:0] diff;
  logic [2:0]         target;
  always_comb begin
    diff   = winter ? 24'(sp) - 24'(t_in) : 24'(t_in) - 24'(sp);
    target = 3'h0;
    for (int k = 1; k <= `CCS_NCOMP; k++) begin
      if (!diff[23] && 3'(k) <= n_steps &&
          diff * 24'(n_steps) >= 24'(k) * 24'(cfg_q[`CCS_IX_PBAND])) begin
        target = 3'(k);
      end
    end
  end

  logic above, below, on_zone, off_zone;
  assign above    = t_out > sp + half;
  assign below    = t_out < sp - half;
  assign on_zone  = winter ? below : above;
  assign off_zone = winter ? above : below;

  logic [15:0] zone_tmr_q;
  logic        req_on, req_off, do_on, do_off;
  always_comb begin
    req_on  = 1'b0;
    req_off = 1'b0;
    if (tick && reg_ok && run_en) begin
      if (ctrl_q[`CCS_F_CTYPE] == `CCS_CT_SIDE) begin
        req_on  = running < target;
        req_off = running > target;
      end else begin
        req_on  = on_zone && zone_tmr_q == 16'h0;
        req_off = off_zone && zone_tmr_q == 16'h0;
      end
    end
  end
  assign do_on  = req_on & found_on;
  assign do_off = req_off & found_off;

  // repeat after extra or release time
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      zone_tmr_q <= '0;
    end else if (i_ce) begin
      if (!(on_zone || off_zone)) zone_tmr_q <= 16'h0;
      else if (req_on) zone_tmr_q <= cfg_q[`CCS_IX_EXTRA];
      else if (req_off) zone_tmr_q <= cfg_q[`CCS_IX_RELEASE];
      else if (tick && zone_tmr_q != 16'h0) zone_tmr_q <= zone_tmr_q - 16'h1;
    end
  end

  // Start pick.
  logic [5:0] cand;
  logic [3:0] idx;
  always_comb begin
    cand = (share ? 1'b0 : !last_circ_q) ? (off_m & ~`CCS_C0_MASK) : (off_m & `CCS_C0_MASK);
    if (cand == 6'h0) cand = off_m;
    found_on = 1'b0;
    pick_on  = 3'h0;
    idx      = 4'h0;
    for (int j = 0; j < `CCS_NCOMP; j++) begin
      idx = 4'(last_off_q) + 4'(j) + 4'h1;
      if (idx >= 4'(`CCS_NCOMP)) idx = idx - 4'(`CCS_NCOMP);
      if (cand[idx[2:0]] && (!found_on || (hmode && hrs_q[idx[2:0]] < hrs_q[pick_on]))) begin
        found_on = 1'b1;
        pick_on  = idx[2:0];
      end
    end
  end

  // Stop pick.
  always_comb begin
    found_off = 1'b0;
    pick_off  = 3'h0;
    for (int i = 0; i < `CCS_NCOMP; i++) begin
      if (on_m[i] && (!found_off || (hmode && hrs_q[i] > hrs_q[pick_off]) ||
          ((!hmode || hrs_q[i] == hrs_q[pick_off]) &&
           (fifo ? age[i] > age[pick_off] : age[i] < age[pick_off])))) begin
        found_off = 1'b1;
        pick_off  = 3'(i);
      end
    end
  end

  always_comb begin
    running = 3'h0;
    for (int i = 0; i < `CCS_NCOMP; i++) begin
      if (st_q[i] == CS_ON || st_q[i] == CS_WAIT_ON) running = running + 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      seq_q       <= '0;
      last_off_q  <= 3'(`CCS_NCOMP - 1);
      last_circ_q <= 1'b1;
      hr_starts_q <= '0;
    end else if (i_ce) begin
      if (do_on) begin
        seq_q       <= seq_q + 8'h1;
        last_circ_q <= pick_on >= `CCS_CIRC1_IX;
      end
      if (do_off) last_off_q <= pick_off;
      if (hour_tick) hr_starts_q <= {7'h0, do_on};
      else if (do_on) hr_starts_q <= hr_starts_q + 8'h1;
    end
  end

  for (genvar g = 0; g < `CCS_NCOMP; g++) begin : g_cmp
    logic [15:0] on_tmr_q;
    logic [11:0] secs_q;
    logic [7:0]  starts_q, stamp_q;
    logic        out_q, start;

    assign cfgd[g]      = 2'(g % `CCS_PER_CIRC) < cpc && (g < `CCS_PER_CIRC || twin);
    assign on_m[g]      = st_q[g] == CS_ON;
    assign off_m[g]     = st_q[g] == CS_OFF;
    assign age[g]       = seq_q - stamp_q;
    assign start        = st_d[g] == CS_ON && st_q[g] != CS_ON;
    assign o_comp_on[g] = out_q;

    always_comb begin
      st_d[g] = st_q[g];
      if (!cfgd[g]) begin
        st_d[g] = CS_DISABLED;
      end else if (s2_q.prot[g]) begin
        st_d[g] = CS_ALARM;
      end else if (s2_q.man[g]) begin
        st_d[g] = CS_MANUAL;
      end else begin
        unique case (st_q[g])
          CS_DISABLED, CS_ALARM, CS_MANUAL: st_d[g] = CS_OFF;
          CS_OFF: begin
            if (do_on && pick_on == 3'(g)) st_d[g] = starts_q >= max_st ? CS_WAIT_ON : CS_ON;
          end
          CS_WAIT_ON: begin
            if (!run_en) st_d[g] = CS_OFF;
            else if (starts_q < max_st) st_d[g] = CS_ON;
          end
          CS_ON: begin
            if (!run_en || (do_off && pick_off == 3'(g))) begin
              st_d[g] = on_tmr_q < cfg_q[`CCS_IX_MIN_ON] ? CS_WAIT_OFF : CS_OFF;
            end
          end
          CS_WAIT_OFF: begin
            if (on_tmr_q >= cfg_q[`CCS_IX_MIN_ON]) st_d[g] = CS_OFF;
          end
        endcase
      end
    end

    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        st_q[g]  <= CS_DISABLED;
        out_q    <= 1'b0;
        on_tmr_q <= '0;
        starts_q <= '0;
        stamp_q  <= '0;
      end else if (i_ce) begin
        st_q[g] <= st_d[g];
        out_q   <= st_d[g] == CS_ON || st_d[g] == CS_WAIT_OFF;
        if (start) begin
          on_tmr_q <= 16'h0;
          stamp_q  <= seq_q;
        end else if (tick && out_q && on_tmr_q != 16'hFFFF) begin
          on_tmr_q <= on_tmr_q + 16'h1;
        end
        // Clearing first means a start in the boundary cycle still counts.
        if (hour_tick) starts_q <= {7'h0, start};
        else if (start) starts_q <= starts_q + 8'h1;
      end
    end

    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        hrs_q[g] <= '0;
        secs_q   <= '0;
      end else if (i_ce) begin
        if (wr_en && hrs_hit && hrs_ix == 3'(g) && i_pwdata == 32'h0) begin
          hrs_q[g] <= 16'h0;
          secs_q   <= 12'h0;
        end else if (tick && out_q) begin
          if (secs_q == 12'(`CCS_HOUR_S - 1)) begin
            secs_q   <= 12'h0;
            hrs_q[g] <= hrs_q[g] + 16'h1;
          end else begin
            secs_q <= secs_q + 12'h1;
          end
        end
      end
    end
  end

  // Read data is staged in the setup cycle so the access phase sees flops.
  logic [31:0] rd;
  logic        hit;
  always_comb begin
    rd  = 32'h0;
    hit = 1'b1;
    if (i_paddr == `CCS_A_CTRL) begin
      rd = {16'h0, ctrl_q};
    end else if (cfg_hit) begin
      rd = {16'h0, cfg_q[cfg_ix]};
    end else if (i_paddr == `CCS_A_STAT) begin
      rd = {19'h0, reg_ok, target, running, o_comp_on};
    end else if (i_paddr == `CCS_A_BAND) begin
      rd = {16'h0, band_q};
    end else if (i_paddr == `CCS_A_STATE) begin
      for (int i = 0; i < `CCS_NCOMP; i++) rd[3*i +: 3] = st_q[i];
    end else if (hrs_hit) begin
      rd = {16'h0, hrs_q[hrs_ix]};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (i_ce && i_psel && !i_penable) begin
      o_prdata  <= i_pwrite ? 32'h0 : rd;
      o_pslverr <= !hit;
    end
  end

endmodule // ccs_top
`default_nettype wire

/* inc/ccs_map.svh */
// Purpose: Address map, field positions, reset values and timing for the staging block.
// Assumes: Temperatures and bands are signed tenths of a degree; times are seconds.
// Notes:   Definitions only.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

`define CCS_CLK_HZ     25000000
`define CCS_TICK_S     1
`define CCS_HOUR_S     3600
`define CCS_NCOMP      6
`define CCS_PER_CIRC   3
`define CCS_NCFG       14

`define CCS_A_CTRL     8'h00
`define CCS_A_CFG_LO   8'h04
`define CCS_A_CFG_HI   8'h38
`define CCS_A_STAT     8'h40
`define CCS_A_BAND     8'h44
`define CCS_A_STATE    8'h48
`define CCS_A_HRS_LO   8'h4C
`define CCS_A_HRS_HI   8'h60

`define CCS_F_CTYPE    0
`define CCS_F_WINTER   1
`define CCS_F_ADAPT    2
`define CCS_F_ROT      4:3
`define CCS_F_LIFO     3
`define CCS_F_HOURS    4
`define CCS_F_SHARE    5
`define CCS_F_NCIRC    7:6
`define CCS_F_CPC      9:8
`define CCS_F_RUN      10
`define CCS_CTRL_RST   16'h0140
`define CCS_CT_SIDE    1'h0
`define CCS_TWIN       2'h2

`define CCS_IX_SP_SUM  0
`define CCS_IX_SP_WIN  1
`define CCS_IX_PBAND   2
`define CCS_IX_DBAND   3
`define CCS_IX_BMIN    4
`define CCS_IX_BMAX    5
`define CCS_IX_CH_LO   6
`define CCS_IX_CH_HI   7
`define CCS_IX_HT_LO   8
`define CCS_IX_HT_HI   9
`define CCS_IX_EXTRA   10
`define CCS_IX_RELEASE 11
`define CCS_IX_MIN_ON  12
`define CCS_IX_MAXST   13

`define CCS_RST_CFG '{16'h0046, 16'h01C2, 16'h0028, 16'h0014, 16'h000A, 16'h0032, \
  16'h0032, 16'h00C8, 16'h012C, 16'h0226, 16'h003C, 16'h003C, 16'h001E, 16'h000A}
`define CCS_RST_DBAND  16'h0014
`define CCS_C0_MASK    6'h07
`define CCS_CIRC1_IX   3'h3

`endif

/* inc/ccs_pkg.sv */
// Purpose: Types shared by the compressor staging block.
// Assumes: Six compressors, three per circuit.
// Notes:   Pin group travels as one packed struct through the synchroniser.
`default_nettype none
package ccs_pkg;
  typedef enum logic [2:0] {
    CS_DISABLED, CS_ON, CS_WAIT_ON, CS_OFF, CS_WAIT_OFF, CS_ALARM, CS_MANUAL
  } ccs_cmp_state_t;

  typedef struct packed {
    logic [15:0] inlet;
    logic [15:0] out_a;
    logic [15:0] out_b;
    logic [1:0]  fail;
    logic [5:0]  prot;
    logic [5:0]  man;
  } ccs_pins_t;
endpackage
`default_nettype wire

/* testbench/ccs_plant.sv */
// Purpose: Water probes seen by the staging block, one water temperature for both outlets.
// Assumes: Inlet water runs 5.0 degrees above the outlet water.
// Notes:   A failed probe inverts every bit each cycle, so it alternates between its last reading and that reading inverted.
`default_nettype none
module ccs_plant (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_water,
  input  wire logic [1:0]  i_fail,
  output logic [15:0]      o_inlet_temp,
  output var logic [15:0]  o_outlet_temp_a,
  output var logic [15:0]  o_outlet_temp_b,
  output logic [1:0]       o_probe_fail
);
  assign o_inlet_temp = i_water + 16'h0032;
  assign o_probe_fail = i_fail;
  initial begin
    o_outlet_temp_a = 16'h0000;
    o_outlet_temp_b = 16'h0000;
  end
  always @(posedge i_sys_clk) begin
    o_outlet_temp_a <= i_fail[0] ? ~o_outlet_temp_a : i_water;
    o_outlet_temp_b <= i_fail[1] ? ~o_outlet_temp_b : i_water;
  end
endmodule // ccs_plant
`default_nettype wire

/* testbench/ccs_top_props.sv */
// Purpose: Port-level properties of the compressor staging block.
// Assumes: One clock domain; steps are decided only at the regulation tick.
// Notes:   Pin effects allow for the two-stage input synchroniser.
`default_nettype none
module ccs_top_chk #(
  parameter int unsigned SEC_CYCLES = 25000000
) (
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic [1:0]  i_probe_fail,
  input wire logic [5:0]  i_prot_trip,
  input wire logic [5:0]  i_manual_mode,
  input wire logic [5:0]  o_comp_on
);
  logic [5:0]  on_q;
  logic [15:0] gap_q;
  logic        rise;
  assign rise = |(o_comp_on & ~on_q);
  always_ff @(posedge i_sys_clk) begin
    on_q <= o_comp_on;
  end
  // Saturates so that the first start after reset is always allowed.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst)
      gap_q <= 16'hFFFF;
    else if (rise)
      gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF)
      gap_q <= gap_q + 16'h0001;
  end
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  AST_RST_OFF: assert property ($past(i_srst) |-> o_comp_on == 6'h00)
    else $error("compressor driven right after reset");
  AST_ONE_RISE: assert property ($countones(o_comp_on & ~on_q) <= 1)
    else $error("two compressors started at once");
  AST_RISE_GAP: assert property (rise |-> gap_q >= 16'(SEC_CYCLES - 1))
    else $error("compressor starts closer than one tick");
  AST_PROBES_DEAD: assert property ((i_probe_fail == 2'h3) [*6] |-> !rise)
    else $error("start with both probes failed");
  AST_PROT_OFF: assert property (
    (o_comp_on & i_prot_trip & $past(i_prot_trip) & $past(i_prot_trip, 2)
     & $past(i_prot_trip, 3) & $past(i_prot_trip, 4)) == 6'h00)
    else $error("tripped compressor still driven");
  AST_MAN_OFF: assert property (
    (o_comp_on & i_manual_mode & $past(i_manual_mode) & $past(i_manual_mode, 2)
     & $past(i_manual_mode, 3) & $past(i_manual_mode, 4)) == 6'h00)
    else $error("manual compressor still driven");
  AST_PREADY: assert property (o_pready == i_ce)
    else $error("ready does not follow clock enable");
  AST_ERR_HIGH: assert property (i_psel && i_penable && $past(i_ce)
    && i_paddr > 8'h60 |-> o_pslverr)
    else $error("unmapped access without error");
  AST_ERR_LOW: assert property (i_psel && i_penable && $past(i_ce) && i_paddr <= 8'h38
    && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("mapped access with error");
  AST_RD_ZERO: assert property (i_psel && i_penable && !i_pwrite && $past(i_ce)
    && i_paddr > 8'h60 |-> o_prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // ccs_top_chk

bind ccs_top ccs_top_chk #(.SEC_CYCLES(SEC_CYCLES)) ccs_top_chk_i (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_probe_fail(i_probe_fail),
  .i_prot_trip(i_prot_trip), .i_manual_mode(i_manual_mode), .o_comp_on(o_comp_on));
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the compressor staging block.
// Assumes: Clock enable high except one freeze test; one regulation tick every ten clocks.
// Notes:   An hour is too long to run, so run hours are only seen at their reset value.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SEC = 10;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } ccs_row_t;
  logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] water, inlet, out_a, out_b;
  logic [1:0]  fail_set, fail;
  logic [5:0]  trip, man, comp, prev, snap;
  int          errors, check_count;
  int          order[$];
  // Reset values of the register table; the last two rows are unmapped.
  ccs_row_t    rows [10] = '{
    '{8'h00, 32'h140, 1'b0}, '{8'h04, 32'h46, 1'b0}, '{8'h08, 32'h1C2, 1'b0},
    '{8'h10, 32'h14, 1'b0}, '{8'h34, 32'h1E, 1'b0}, '{8'h38, 32'hA, 1'b0},
    '{8'h44, 32'h14, 1'b0}, '{8'h4C, 32'h0, 1'b0}, '{8'h3C, 32'h0, 1'b1},
    '{8'h64, 32'h0, 1'b1}};

  ccs_plant ccs_plant_i (.i_sys_clk(clk), .i_water(water), .i_fail(fail_set),
    .o_inlet_temp(inlet), .o_outlet_temp_a(out_a), .o_outlet_temp_b(out_b),
    .o_probe_fail(fail));
  ccs_top #(.SEC_CYCLES(SEC)) ccs_top_i (.i_sys_clk(clk), .i_srst(srst), .i_ce(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_inlet_temp(inlet), .i_outlet_temp_a(out_a), .i_outlet_temp_b(out_b),
    .i_probe_fail(fail), .i_prot_trip(trip), .i_manual_mode(man), .o_comp_on(comp));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Start order is logged so switch-off order can be judged later.
  always @(posedge clk) begin
    prev <= comp;
    for (int k = 0; k < 6; k++)
      if (comp[k] && !prev[k]) order.push_back(k);
  end

  task automatic stop_test();
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Returns at a falling edge, where outputs have settled.
  task automatic wait_cnt(input int n);
    int c;
    c = 0;
    while ($countones(comp) != n && c < 600) begin
      @(negedge clk);
      c++;
    end
    if ($countones(comp) != n) begin
      errors++;
      stop_test();
    end
  endtask

  initial begin
    errors = 0;
    check_count = 0;
    srst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    water = 16'h0037;
    fail_set = 2'h0;
    trip = 6'h00;
    man = 6'h00;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    // Short zone times, then a summer setpoint below its low limit.
    apb(1'b1, 8'h2C, 32'h1);
    apb(1'b1, 8'h30, 32'h1);
    apb(1'b1, 8'h34, 32'h3);
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b1, 8'h00, 32'h781);
    repeat (60) @(negedge clk);
    chk({26'h0, comp}, 32'h0);
    @(posedge clk);
    water <= 16'h0064;
    wait_cnt(2);
    chk({30'h0, |comp[5:3], |comp[2:0]}, 32'h3);
    @(posedge clk);
    fail_set <= 2'h3;
    repeat (5) @(negedge clk);
    snap = comp;
    repeat (60) @(negedge clk);
    chk({26'h0, comp}, {26'h0, snap});
    @(posedge clk);
    fail_set <= 2'h1;
    wait_cnt(3);
    @(posedge clk);
    trip <= 6'h01 << order[0];
    repeat (6) @(negedge clk);
    chk({31'h0, comp[order[0]]}, 32'h0);
    wait_cnt(3);
    chk({31'h0, comp[order[0]]}, 32'h0);
    @(posedge clk);
    trip <= 6'h00;
    fail_set <= 2'h0;
    water <= 16'h001E;
    wait_cnt(2);
    chk({31'h0, comp[order[1]]}, 32'h0);
    snap = comp;
    // Off requests would drop both units within forty clocks unless frozen.
    @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(negedge clk);
    chk({26'h0, comp}, {26'h0, snap});
    chk({31'h0, pready}, 32'h0);
    @(posedge clk);
    ce  <= 1'b1;
    man <= 6'h3F;
    repeat (6) @(negedge clk);
    chk({26'h0, comp}, 32'h0);
    // A reset in mid-run must bring the written summer setpoint and control registers back.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    man  <= 6'h00;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h46);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h140);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
